// ---- logic/oepc_pkg.sv ----
// Constants shared by the OTP/EEPROM programming control block
package oepc_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [13:0] IDX_CTRL      = 14'h0007;
    localparam logic [13:0] IDX_OPTS      = 14'h0100;
    localparam logic [13:0] IDX_FACT      = 14'h3dfe;
    // Control register bit positions
    localparam int          CTL_OTP_LATCH = 5;
    localparam int          CTL_OTP_PROG  = 4;
    localparam int          CTL_ERASE     = 2;
    localparam int          CTL_EE_LATCH  = 1;
    localparam int          CTL_PUMP      = 0;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    // Options register bit positions and erased value
    localparam int          OPT_UNPROT    = 1;
    localparam int          OPT_SECURE    = 0;
    localparam logic [1:0]  OPTS_ERASED   = 2'h3;
    // Factory option bit positions
    localparam int          FO_SHORT_RST  = 4;
    localparam int          FO_WDOG_RST   = 3;
    localparam int          FO_WDOG_WAIT  = 2;
    localparam int          FO_PB_PD      = 1;
    localparam int          FO_PC_PD      = 0;
    // Memory map of the core-side access port
    localparam logic [13:0] EE_BASE       = 14'h0100;
    localparam logic [13:0] EE_LAST       = 14'h01ff;
    localparam logic [13:0] OTP_BASE      = 14'h0250;
    localparam logic [13:0] OTP_LAST      = 14'h3dff;
    localparam logic [7:0]  EE_PROT_START = 8'h20;
    // Reset pin hold after power-on, in clock cycles
    localparam logic [11:0] POR_SHORT     = 12'h010;
    localparam logic [11:0] POR_LONG      = 12'hfe0;
    // EEPROM control state, {erase, latch, pump}
    typedef enum logic [2:0] {
        EE_READ       = 3'h0,
        EE_LOAD       = 3'h2,
        EE_PROG       = 3'h3,
        EE_ERASE_LOAD = 3'h6,
        EE_ERASE      = 3'h7
    } oepc_ee_state_e;
endpackage : oepc_pkg

// ---- logic/oepc_sync.sv ----
// Three-stage pin synchroniser with agreement filter
module oepc_sync (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // Pin and filtered level
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A change counts only once the later two stages agree
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            level_out <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            level_out <= s3_ff;
        end
    end
endmodule : oepc_sync

// ---- logic/oepc_por_timer.sv ----
// Reset pin hold timer started at power-on release
module oepc_por_timer (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // Length select and hold output
    input  wire logic short_in,
    output logic      hold_out
);
    logic [11:0] cnt_ff;
    logic        started_ff;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cnt_ff     <= 12'h000;
            started_ff <= 1'b0;
            hold_out   <= 1'b1;
        end else if (!started_ff) begin
            // Length is picked after release so the option is a settled level
            cnt_ff     <= (short_in ? oepc_pkg::POR_SHORT : oepc_pkg::POR_LONG) - 12'h001;
            started_ff <= 1'b1;
        end else if (cnt_ff != 12'h000) begin
            cnt_ff <= cnt_ff - 12'h001;
        end else begin
            hold_out <= 1'b0;
        end
    end
endmodule : oepc_por_timer

// ---- logic/oepc_nvm_ctrl.sv ----
// OTP/EEPROM programming control with option bits, Wishbone register slave
module oepc_nvm_ctrl #(
    // Factory option bits, as programmed in the part
    parameter logic [4:0] FACTORY_OPTS = 5'h00
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [15:0] wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Core status and memory write port
    input  wire logic        stop_in,
    input  wire logic        wait_in,
    input  wire logic        bootstrap_in,
    input  wire logic        ext_reset_pin_in,
    input  wire logic        wdog_active_in,
    input  wire logic        mem_wr_in,
    input  wire logic [13:0] mem_adr_in,
    input  wire logic [7:0]  mem_dat_in,
    input  wire logic [7:0]  ddrb_in,
    input  wire logic [7:0]  ddrc_in,
    // OTP programming outputs
    output logic             otp_read_valid_out,
    output logic             otp_prog_out,
    output logic      [10:0] otp_group_out,
    output logic      [7:0]  otp_mask_out,
    output logic      [63:0] otp_data_out,
    // EEPROM programming outputs
    output logic      [2:0]  ee_state_out,
    output logic             ee_hv_out,
    output logic             ee_commit_out,
    output logic      [7:0]  ee_addr_out,
    output logic      [7:0]  ee_data_out,
    // Option-driven outputs
    output logic             reset_hold_out,
    output logic             wdog_after_reset_out,
    output logic             wdog_run_out,
    output logic      [7:0]  portb_pd_out,
    output logic      [7:0]  portc_pd_out,
    output logic             nonuser_allowed_out
);
    logic        ext_rst_lvl;
    logic        por_hold;
    logic        clr_latch;
    logic        ctl_wr;
    logic        opt_wr;
    logic        otp_hit;
    logic        ee_hit;
    logic        ee_protected;
    logic [7:0]  ctrl_rd;
    logic [1:0]  opts_ff;
    logic        eff_unprot_ff;
    logic        eff_secure_ff;
    logic        wdog_rst_ff;
    logic        cap_ff;
    logic        ee_loaded_ff;
    logic        otp_latch_ff;
    logic        otp_prog_ff;
    logic        ee_latch_ff;
    logic        erase_ff;
    logic        pump_ff;
    logic [7:0]  otp_byte_ff [8];
    oepc_pkg::oepc_ee_state_e ee_state;

    function automatic logic in_range(input logic [13:0] a, input logic [13:0] lo,
                                      input logic [13:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    oepc_sync u_ext_rst (
        .clock_in  (clock_in),
        .srst_in   (srst_in),
        .pin_in    (ext_reset_pin_in),
        .level_out (ext_rst_lvl)
    );

    oepc_por_timer u_por (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .short_in (FACTORY_OPTS[oepc_pkg::FO_SHORT_RST]),
        .hold_out (por_hold)
    );

    // Register bus decode
    assign ctl_wr    = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0]
                       && (wb_adr_in[15:2] == oepc_pkg::IDX_CTRL);
    assign opt_wr    = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0]
                       && (wb_adr_in[15:2] == oepc_pkg::IDX_OPTS);
    assign clr_latch = stop_in || ext_rst_lvl;
    assign otp_hit   = mem_wr_in && in_range(mem_adr_in, oepc_pkg::OTP_BASE, oepc_pkg::OTP_LAST);
    assign ee_hit    = mem_wr_in && in_range(mem_adr_in, oepc_pkg::EE_BASE, oepc_pkg::EE_LAST);
    // Protection uses the value captured at reset, not the live option bit
    assign ee_protected = !eff_unprot_ff && !bootstrap_in
                          && (ee_addr_out >= oepc_pkg::EE_PROT_START);

    always_comb begin
        ctrl_rd = oepc_pkg::CTRL_RST;
        ctrl_rd[oepc_pkg::CTL_OTP_LATCH] = otp_latch_ff;
        ctrl_rd[oepc_pkg::CTL_OTP_PROG]  = otp_prog_ff;
        ctrl_rd[oepc_pkg::CTL_ERASE]     = erase_ff;
        ctrl_rd[oepc_pkg::CTL_EE_LATCH]  = ee_latch_ff;
        ctrl_rd[oepc_pkg::CTL_PUMP]      = pump_ff;
    end

    // One wait-free ack per request; unmapped words read zero
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
            wb_dat_out <= 32'h0000_0000;
            if (wb_adr_in[15:2] == oepc_pkg::IDX_CTRL) begin
                wb_dat_out[7:0] <= ctrl_rd;
            end else if (wb_adr_in[15:2] == oepc_pkg::IDX_OPTS) begin
                wb_dat_out[1:0] <= opts_ff;
            end else if (wb_adr_in[15:2] == oepc_pkg::IDX_FACT) begin
                wb_dat_out[4:0] <= FACTORY_OPTS;
            end
        end
    end

    // OTP latch and program-enable
    always_ff @(posedge clock_in) begin
        if (srst_in || clr_latch) begin
            otp_latch_ff <= 1'b0;
            otp_prog_ff  <= 1'b0;
        end else if (ctl_wr) begin
            otp_latch_ff <= wb_dat_in[oepc_pkg::CTL_OTP_LATCH];
            if (!wb_dat_in[oepc_pkg::CTL_OTP_LATCH]) begin
                otp_prog_ff <= 1'b0;
            end else if (otp_latch_ff && (otp_mask_out != 8'h00)
                         && wb_dat_in[oepc_pkg::CTL_OTP_PROG]) begin
                otp_prog_ff <= 1'b1;
            end
        end
    end

    // OTP address group and byte capture
    always_ff @(posedge clock_in) begin
        if (srst_in || clr_latch || !otp_latch_ff) begin
            otp_group_out <= 11'h000;
            otp_mask_out  <= 8'h00;
        end else if (otp_hit && !otp_prog_ff) begin
            // First byte fixes the group; others outside it are dropped
            if (otp_mask_out == 8'h00) begin
                otp_group_out <= mem_adr_in[13:3];
                otp_mask_out  <= 8'h01 << mem_adr_in[2:0];
            end else if (mem_adr_in[13:3] == otp_group_out) begin
                otp_mask_out[mem_adr_in[2:0]] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            for (int i = 0; i < 8; i++) begin
                otp_byte_ff[i] <= 8'h00;
            end
        end else if (otp_latch_ff && !otp_prog_ff && otp_hit
                     && ((otp_mask_out == 8'h00) || (mem_adr_in[13:3] == otp_group_out))) begin
            otp_byte_ff[mem_adr_in[2:0]] <= mem_dat_in;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            otp_data_out[i*8 +: 8] = otp_byte_ff[i];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            otp_prog_out       <= 1'b0;
            otp_read_valid_out <= 1'b1;
        end else begin
            otp_prog_out       <= otp_prog_ff;
            otp_read_valid_out <= !otp_latch_ff;
        end
    end

    // EEPROM latch, erase-select and pump
    always_ff @(posedge clock_in) begin
        if (srst_in || clr_latch) begin
            ee_latch_ff <= 1'b0;
            erase_ff    <= 1'b0;
            pump_ff     <= 1'b0;
        end else if (ctl_wr) begin
            ee_latch_ff <= wb_dat_in[oepc_pkg::CTL_EE_LATCH];
            if (!wb_dat_in[oepc_pkg::CTL_EE_LATCH]) begin
                erase_ff <= 1'b0;
                pump_ff  <= 1'b0;
            end else begin
                if (!ee_loaded_ff) begin
                    erase_ff <= wb_dat_in[oepc_pkg::CTL_ERASE];
                end
                if (ee_loaded_ff && ee_latch_ff && wb_dat_in[oepc_pkg::CTL_PUMP]) begin
                    pump_ff <= 1'b1;
                end
            end
        end
    end

    // EEPROM address and data capture; the first write wins
    always_ff @(posedge clock_in) begin
        if (srst_in || clr_latch || !ee_latch_ff) begin
            ee_loaded_ff <= 1'b0;
            ee_addr_out  <= 8'h00;
            ee_data_out  <= 8'h00;
        end else if (ee_hit && !pump_ff && !ee_loaded_ff) begin
            ee_loaded_ff <= 1'b1;
            ee_addr_out  <= mem_adr_in[7:0];
            ee_data_out  <= mem_dat_in;
        end
    end

    always_comb begin
        ee_state = oepc_pkg::oepc_ee_state_e'({erase_ff, ee_latch_ff, pump_ff});
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ee_state_out  <= oepc_pkg::EE_READ;
            ee_hv_out     <= 1'b0;
            ee_commit_out <= 1'b0;
        end else begin
            ee_state_out <= ee_state;
            ee_hv_out    <= pump_ff;
            case (ee_state)
                oepc_pkg::EE_PROG,
                oepc_pkg::EE_ERASE: begin
                    ee_commit_out <= !ee_protected;
                end
                default: begin
                    ee_commit_out <= 1'b0;
                end
            endcase
        end
    end

    // Options register; erased bits are ones
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            opts_ff <= oepc_pkg::OPTS_ERASED;
        end else if (opt_wr) begin
            opts_ff[oepc_pkg::OPT_SECURE] <= wb_dat_in[oepc_pkg::OPT_SECURE];
            if (wb_dat_in[oepc_pkg::OPT_UNPROT] || ee_latch_ff) begin
                opts_ff[oepc_pkg::OPT_UNPROT] <= wb_dat_in[oepc_pkg::OPT_UNPROT];
            end
        end
    end

    // Option values caught once after each reset release
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cap_ff        <= 1'b1;
            eff_unprot_ff <= 1'b0;
            eff_secure_ff <= 1'b0;
            wdog_rst_ff   <= 1'b0;
        end else if (ext_rst_lvl) begin
            cap_ff <= 1'b1;
        end else if (cap_ff) begin
            cap_ff        <= 1'b0;
            eff_unprot_ff <= opts_ff[oepc_pkg::OPT_UNPROT];
            eff_secure_ff <= opts_ff[oepc_pkg::OPT_SECURE];
            wdog_rst_ff   <= FACTORY_OPTS[oepc_pkg::FO_WDOG_RST] && !bootstrap_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reset_hold_out       <= 1'b1;
            wdog_after_reset_out <= 1'b0;
            wdog_run_out         <= 1'b0;
            portb_pd_out         <= 8'h00;
            portc_pd_out         <= 8'h00;
            nonuser_allowed_out  <= 1'b0;
        end else begin
            reset_hold_out       <= por_hold;
            wdog_after_reset_out <= wdog_rst_ff;
            wdog_run_out         <= wdog_active_in
                                    && (!wait_in || FACTORY_OPTS[oepc_pkg::FO_WDOG_WAIT]);
            portb_pd_out <= {8{FACTORY_OPTS[oepc_pkg::FO_PB_PD]}} & ~ddrb_in;
            portc_pd_out <= {8{FACTORY_OPTS[oepc_pkg::FO_PC_PD]}} & ~ddrc_in;
            nonuser_allowed_out  <= eff_secure_ff;
        end
    end

    // Checks
    sequence s_ee_clear;
        ctl_wr && !wb_dat_in[oepc_pkg::CTL_EE_LATCH];
    endsequence

    property p_prog_needs_latch;
        @(posedge clock_in) disable iff (srst_in)
        otp_prog_ff |-> otp_latch_ff && (otp_mask_out != 8'h00);
    endproperty
    a_prog_needs_latch: assert property (p_prog_needs_latch)
        else $error("program enable without latch or byte");

    property p_prog_sticky;
        @(posedge clock_in) disable iff (srst_in)
        otp_prog_ff && !clr_latch && !(ctl_wr && !wb_dat_in[oepc_pkg::CTL_OTP_LATCH])
        |=> otp_prog_ff;
    endproperty
    a_prog_sticky: assert property (p_prog_sticky)
        else $error("program enable cleared without latch clear");

    property p_stop_clears;
        @(posedge clock_in) disable iff (srst_in)
        stop_in |=> !otp_latch_ff && !ee_latch_ff ##2 !ee_hv_out;
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("stop did not clear latches");

    property p_ee_clear;
        @(posedge clock_in) disable iff (srst_in)
        s_ee_clear |=> !erase_ff && !pump_ff ##1 ee_state_out == oepc_pkg::EE_READ;
    endproperty
    a_ee_clear: assert property (p_ee_clear)
        else $error("erase or pump survived latch clear");

    property p_pump_needs_data;
        @(posedge clock_in) disable iff (srst_in)
        $rose(pump_ff) |-> $past(ee_loaded_ff);
    endproperty
    a_pump_needs_data: assert property (p_pump_needs_data)
        else $error("pump set before data latched");

    property p_erase_frozen;
        @(posedge clock_in) disable iff (srst_in)
        ee_loaded_ff && ee_latch_ff && !clr_latch
        && !(ctl_wr && !wb_dat_in[oepc_pkg::CTL_EE_LATCH])
        |=> $stable(erase_ff);
    endproperty
    a_erase_frozen: assert property (p_erase_frozen)
        else $error("erase select changed after address latched");

    property p_protect;
        @(posedge clock_in) disable iff (srst_in)
        ee_protected |=> !ee_commit_out;
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected EEPROM byte committed");

    property p_read_valid;
        @(posedge clock_in) disable iff (srst_in)
        otp_latch_ff |=> !otp_read_valid_out;
    endproperty
    a_read_valid: assert property (p_read_valid)
        else $error("OTP read valid while latched");

    property p_pulldown;
        @(posedge clock_in) disable iff (srst_in)
        ddrb_in[0] |=> !portb_pd_out[0];
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pull-down on an output pin");
endmodule : oepc_nvm_ctrl

// ---- tb/oepc_nvm_ctrl_bench.sv ----
// Self-checking bench for the OTP/EEPROM programming control block
module oepc_nvm_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Short reset, watchdog after reset, no watchdog in wait, both pull-downs
    localparam logic [4:0]  FOPTS = 5'h1b;
    localparam logic [15:0] A_CTL = {oepc_pkg::IDX_CTRL, 2'b00};
    localparam logic [15:0] A_OPT = {oepc_pkg::IDX_OPTS, 2'b00};
    localparam logic [15:0] A_FAC = {oepc_pkg::IDX_FACT, 2'b00};
    logic        clock_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
    logic [15:0] wb_adr_in;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out;
    logic        stop_in, wait_in, bootstrap_in, ext_reset_pin_in, wdog_active_in, mem_wr_in;
    logic [13:0] mem_adr_in;
    logic [7:0]  mem_dat_in, ddrb_in, ddrc_in, otp_mask_out, ee_addr_out, ee_data_out;
    logic [7:0]  portb_pd_out, portc_pd_out;
    logic        otp_read_valid_out, otp_prog_out, ee_hv_out, ee_commit_out, reset_hold_out;
    logic        wdog_after_reset_out, wdog_run_out, nonuser_allowed_out;
    logic [10:0] otp_group_out;
    logic [63:0] otp_data_out;
    logic [2:0]  ee_state_out;
    int          miscompares, samples_checked;
    logic [31:0] exp_q[$];

    oepc_nvm_ctrl #(.FACTORY_OPTS(FOPTS)) dut (
        .clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .stop_in(stop_in), .wait_in(wait_in), .bootstrap_in(bootstrap_in),
        .ext_reset_pin_in(ext_reset_pin_in), .wdog_active_in(wdog_active_in),
        .mem_wr_in(mem_wr_in), .mem_adr_in(mem_adr_in), .mem_dat_in(mem_dat_in),
        .ddrb_in(ddrb_in), .ddrc_in(ddrc_in), .otp_read_valid_out(otp_read_valid_out),
        .otp_prog_out(otp_prog_out), .otp_group_out(otp_group_out),
        .otp_mask_out(otp_mask_out), .otp_data_out(otp_data_out),
        .ee_state_out(ee_state_out), .ee_hv_out(ee_hv_out), .ee_commit_out(ee_commit_out),
        .ee_addr_out(ee_addr_out), .ee_data_out(ee_data_out),
        .reset_hold_out(reset_hold_out), .wdog_after_reset_out(wdog_after_reset_out),
        .wdog_run_out(wdog_run_out), .portb_pd_out(portb_pd_out),
        .portc_pd_out(portc_pd_out), .nonuser_allowed_out(nonuser_allowed_out));

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    // Read results are paired with the oldest expectation at the acknowledging edge
    always @(posedge clock_in) begin
        if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
            if (exp_q.size() == 0) check("unexpected_read", 64'h1, 64'h0);
            else check("wb_dat_out", {32'h0, exp_q.pop_front()}, {32'h0, wb_dat_out});
        end
    end

    task automatic wb(input logic we, input logic [15:0] adr, input logic [7:0] d,
                      input logic [7:0] exp);
        bit got;
        got = 1'b0;
        @(posedge clock_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_dat_in <= {24'h0, d};
        if (!we) exp_q.push_back({24'h0, exp});
        for (int n = 0; n < 100 && !got; n++) begin
            @(posedge clock_in);
            got = (wb_ack_out === 1'b1);
        end
        if (!got) begin
            miscompares++;
            results();
        end
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in  <= 1'b0;
    endtask : wb

    task automatic mem(input logic [13:0] adr, input logic [7:0] d);
        @(posedge clock_in);
        mem_wr_in  <= 1'b1;
        mem_adr_in <= adr;
        mem_dat_in <= d;
        @(posedge clock_in);
        mem_wr_in  <= 1'b0;
    endtask : mem

    task automatic settle();
        repeat (3) @(posedge clock_in);
        #1;
    endtask : settle

    // Loads one EEPROM byte, runs the pump, then ends the operation by clearing the latch
    task automatic ee_prog(input logic er, input logic [7:0] off, input logic [7:0] d,
                           input logic com);
        wb(1'b1, A_CTL, {5'h0, er, 2'b10}, 8'h00);
        wb(1'b1, A_CTL, {5'h0, er, 2'b11}, 8'h00);
        wb(1'b0, A_CTL, 8'h00, {5'h0, er, 2'b10});
        mem(oepc_pkg::EE_BASE + {6'h0, off}, d);
        settle();
        check("ee_state_load", {61'h0, er, 2'b10}, {61'h0, ee_state_out});
        wb(1'b1, A_CTL, {5'h0, ~er, 2'b11}, 8'h00);
        wb(1'b0, A_CTL, 8'h00, {5'h0, er, 2'b11});
        settle();
        check("ee_state_run", {61'h0, er, 2'b11}, {61'h0, ee_state_out});
        check("ee_hv_out", 64'h1, {63'h0, ee_hv_out});
        check("ee_commit_out", {63'h0, com}, {63'h0, ee_commit_out});
        check("ee_latched", {48'h0, off, d}, {48'h0, ee_addr_out, ee_data_out});
        wb(1'b1, A_CTL, {5'h0, er, 2'b10}, 8'h00);
        wb(1'b0, A_CTL, 8'h00, {5'h0, er, 2'b11});
        wb(1'b1, A_CTL, 8'h00, 8'h00);
        settle();
        check("ee_state_idle", {61'h0, oepc_pkg::EE_READ}, {61'h0, ee_state_out});
        check("ee_hv_off", 64'h0, {63'h0, ee_hv_out});
    endtask : ee_prog

    initial begin : main
        int          n;
        logic [10:0] grp;
        logic [7:0]  d0, d7;
        {srst_in, wb_cyc_in, wb_stb_in, wb_we_in, mem_wr_in, stop_in, wait_in} = 7'h40;
        {bootstrap_in, ext_reset_pin_in, wdog_active_in} = 3'h0;
        {wb_adr_in, wb_sel_in, wb_dat_in, mem_adr_in, mem_dat_in} = '0;
        wb_sel_in = 4'h1;
        {ddrb_in, ddrc_in} = 16'h0;
        miscompares = 0;
        samples_checked = 0;
        n = $urandom(20);
        repeat (4) @(posedge clock_in);
        srst_in <= 1'b0;
        n = 0;
        while (reset_hold_out !== 1'b0 && n < 5000) begin
            @(posedge clock_in);
            n++;
        end
        check("reset_hold_short", 64'h1, {63'h0, n >= 16 && n <= 20});
        check("wdog_after_reset_out", 64'h1, {63'h0, wdog_after_reset_out});
        check("nonuser_allowed_out", 64'h1, {63'h0, nonuser_allowed_out});
        wb(1'b0, A_CTL, 8'h00, oepc_pkg::CTRL_RST);
        wb(1'b1, A_FAC, 8'h00, 8'h00);
        wb(1'b0, A_FAC, 8'h00, {3'h0, FOPTS});
        wb(1'b0, 16'h0040, 8'h00, 8'h00);
        wb(1'b1, A_CTL, 8'h10, 8'h00);
        wb(1'b0, A_CTL, 8'h00, 8'h00);
        wb(1'b1, A_CTL, 8'hff, 8'h00);
        wb(1'b0, A_CTL, 8'h00, 8'h26);
        wb(1'b1, A_CTL, 8'h00, 8'h00);
        // OTP group with two slots filled and one foreign byte refused
        grp = 11'($urandom_range(11'h04b, 11'h7be));
        d0 = 8'($urandom);
        d7 = 8'($urandom);
        wb(1'b1, A_CTL, 8'h20, 8'h00);
        wb(1'b1, A_CTL, 8'h30, 8'h00);
        wb(1'b0, A_CTL, 8'h00, 8'h20);
        settle();
        check("otp_read_valid_out", 64'h0, {63'h0, otp_read_valid_out});
        mem({grp, 3'h0}, d0);
        mem({grp, 3'h7}, d7);
        mem({grp + 11'h1, 3'h2}, 8'h5a);
        settle();
        check("otp_mask_out", 64'h81, {56'h0, otp_mask_out});
        check("otp_group_out", {53'h0, grp}, {53'h0, otp_group_out});
        check("otp_data_out", {48'h0, d7, d0},
              {48'h0, otp_data_out[63:56], otp_data_out[7:0]});
        wb(1'b1, A_CTL, 8'h30, 8'h00);
        wb(1'b1, A_CTL, 8'h20, 8'h00);
        wb(1'b0, A_CTL, 8'h00, 8'h30);
        settle();
        check("otp_prog_out", 64'h1, {63'h0, otp_prog_out});
        wb(1'b1, A_CTL, 8'h00, 8'h00);
        wb(1'b0, A_CTL, 8'h00, 8'h00);
        settle();
        check("otp_prog_cleared", 64'h1, {63'h0, otp_read_valid_out & ~otp_prog_out});
        ee_prog(1'b0, 8'($urandom_range(0, 31)), 8'($urandom), 1'b1);
        ee_prog(1'b1, 8'($urandom_range(0, 31)), 8'($urandom), 1'b1);
        wb(1'b1, A_CTL, 8'h22, 8'h00);
        @(posedge clock_in);
        stop_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        stop_in <= 1'b0;
        wb(1'b0, A_CTL, 8'h00, 8'h00);
        // Option writes: protect may only drop with the EEPROM latch set
        wb(1'b1, A_OPT, 8'h00, 8'h00);
        // Security bit takes the write; protect bit refuses zero without the latch
        wb(1'b0, A_OPT, 8'h00, 8'h02);
        wb(1'b1, A_CTL, 8'h02, 8'h00);
        wb(1'b1, A_OPT, 8'h00, 8'h00);
        wb(1'b0, A_OPT, 8'h00, 8'h00);
        settle();
        check("nonuser_before_reset", 64'h1, {63'h0, nonuser_allowed_out});
        wb(1'b1, A_CTL, 8'h22, 8'h00);
        @(posedge clock_in);
        ext_reset_pin_in <= 1'b1;
        bootstrap_in <= 1'b1;
        repeat (10) @(posedge clock_in);
        ext_reset_pin_in <= 1'b0;
        repeat (12) @(posedge clock_in);
        wb(1'b0, A_CTL, 8'h00, 8'h00);
        settle();
        check("nonuser_after_reset", 64'h0, {63'h0, nonuser_allowed_out});
        check("wdog_after_boot", 64'h0, {63'h0, wdog_after_reset_out});
        ee_prog(1'b0, 8'h80, 8'($urandom), 1'b1);
        @(posedge clock_in);
        bootstrap_in <= 1'b0;
        ee_prog(1'b0, 8'($urandom_range(32, 255)), 8'($urandom), 1'b0);
        ee_prog(1'b1, 8'h1f, 8'($urandom), 1'b1);
        for (n = 0; n < 4; n++) begin
            @(posedge clock_in);
            wait_in <= n[0];
            wdog_active_in <= n[1];
            ddrb_in <= 8'($urandom);
            ddrc_in <= 8'($urandom);
            settle();
            check("wdog_run_out", {63'h0, n[1] & ~n[0]}, {63'h0, wdog_run_out});
            check("portb_pd_out", {56'h0, ~ddrb_in}, {56'h0, portb_pd_out});
            check("portc_pd_out", {56'h0, ~ddrc_in}, {56'h0, portc_pd_out});
        end
        repeat (4) @(posedge clock_in);
        check("reads_pending", 64'h0, 64'(exp_q.size()));
        results();
    end
endmodule : oepc_nvm_ctrl_bench
